// ==== ffbp_assertions.sv ====
// Port-level checks for the flex fuel and boost block
`timescale 1ns/1ps
module ffbp_assertions
    import ffbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic composition_sensor,
    input wire logic [FRAC_W-1:0] lambda_blend_factor_table,
    input wire logic [LAMBDA_W-1:0] base_lambda_target,
    input wire logic [LAMBDA_W-1:0] ethanol_lambda_target,
    input wire logic [FUEL_W-1:0] crank_fuel_base,
    input wire logic [FUEL_W-1:0] ethanol_crank_fuel_extra,
    input wire ffbp_boost_cfg_t boost_cfg,
    input wire ffbp_sensor_t sensor,
    input wire logic [LAMBDA_W-1:0] lambda_target,
    input wire logic [FUEL_W-1:0] crank_fuel_total,
    input wire logic [6:0] boost_duty_applied,
    input wire logic boost_lowside_driver
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_off;
        ce && !boost_cfg.output_enable;
    endsequence
    sequence s_open;
        ce && boost_cfg.output_enable && !boost_cfg.feedback_enable
            && boost_cfg.open_loop_duty <= boost_cfg.max_duty && boost_cfg.max_duty <= 7'h64;
    endsequence
    a_idle_high: assert property (
        s_off |=> boost_lowside_driver && boost_duty_applied == 7'h00)
        else $error("solenoid driven while disabled");
    a_duty_clamp: assert property (
        ce |=> boost_duty_applied <= $past(boost_cfg.max_duty))
        else $error("duty above maximum");
    a_open_loop: assert property (
        s_open |=> boost_duty_applied == $past(boost_cfg.open_loop_duty))
        else $error("open loop duty altered");
    a_crank_sum: assert property (
        ce && {1'b0, crank_fuel_base} + ethanol_crank_fuel_extra < 17'h10000
        |=> crank_fuel_total == $past(crank_fuel_base) + $past(ethanol_crank_fuel_extra))
        else $error("crank sum wrong");
    a_blend_base: assert property (
        ce && lambda_blend_factor_table == 8'h00 |=> lambda_target == $past(base_lambda_target))
        else $error("zero blend not base");
    a_blend_eth: assert property (
        ce && lambda_blend_factor_table == 8'hff
        |=> lambda_target == $past(ethanol_lambda_target))
        else $error("full blend not ethanol");
    a_timeout_hold: assert property (
        $fell(sensor.reading_valid) |-> $stable(sensor.ethanol_content))
        else $error("content lost on timeout");
    a_fail_hold: assert property (
        $rose(sensor.fail_safe) |-> $stable(sensor.ethanol_content))
        else $error("content moved on fail safe");
endmodule : ffbp_assertions

// ==== ffbp_partner.sv ====
// Sensor wave source and solenoid load
`timescale 1ns/1ps
module ffbp_partner (
    input wire logic clk,
    input wire logic [21:0] period,
    input wire logic [21:0] width,
    input wire logic drive_n,
    output logic wave = 1'b0,
    output logic energised
);
    logic [21:0] cnt = 22'h000000;
    // Period zero parks the line low, as an unpowered sensor would
    always @(posedge clk) begin
        cnt <= (cnt + 22'h1 >= period) ? 22'h0 : cnt + 22'h1;
        wave <= (period != 22'h0) && (cnt < width);
    end
    assign energised = !drive_n;
endmodule : ffbp_partner

// ==== ffbp_pkg.sv ====
// Shared constants and carrier types for the flex fuel and boost PWM block
package ffbp_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // Sensor frequency span, Hz
    localparam int unsigned FREQ_MIN_HZ = 50;
    localparam int unsigned FREQ_MAX_HZ = 150;
    localparam int unsigned FREQ_FAIL_HZ = 170;
    // Periods in clock cycles; shortest periods round down
    localparam int unsigned PER_MIN_CYC = CLK_HZ / FREQ_MAX_HZ;
    localparam int unsigned PER_MAX_CYC = CLK_HZ / FREQ_MIN_HZ;
    localparam int unsigned PER_FAIL_CYC = CLK_HZ / FREQ_FAIL_HZ;
    // Pulse width span in microseconds and cycles
    localparam int unsigned PW_MIN_US = 1000;
    localparam int unsigned PW_MAX_US = 5000;
    localparam int unsigned PW_MIN_CYC = PW_MIN_US * (CLK_HZ / 1000000);
    localparam int unsigned PW_MAX_CYC = PW_MAX_US * (CLK_HZ / 1000000);
    localparam int signed TEMP_MIN_C = -40;
    localparam int signed TEMP_MAX_C = 125;
    // Edge timeout: a bit beyond one 50 Hz period
    localparam int unsigned TIMEOUT_CYC = PER_MAX_CYC + PER_MAX_CYC / 4;
    localparam int unsigned CNT_W = 22;
    // Fractions in Q0.8: 8'hff reads as 1.0, percent is 0..100
    localparam int unsigned FRAC_W = 8;
    localparam logic [7:0] FRAC_ONE = 8'hff;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [7:0] ETH_RESET = 8'h00;
    localparam int unsigned LAMBDA_W = 16;
    localparam int unsigned FUEL_W = 16;
    localparam int unsigned PWM_W = 24;

    typedef struct packed {
        logic [6:0] ethanol_content;
        logic signed [7:0] fuel_temp_c;
        logic reading_valid;
        logic fail_safe;
    } ffbp_sensor_t;

    typedef struct packed {
        logic output_enable;
        logic feedback_enable;
        logic [6:0] open_loop_duty;
        logic signed [7:0] feedback_trim;
        logic [6:0] max_duty;
        logic [PWM_W-1:0] period_cycles;
    } ffbp_boost_cfg_t;
endpackage : ffbp_pkg

// ==== ffbp_pwm.sv ====
// Low-active boost solenoid PWM generator
`timescale 1ns/1ps
module ffbp_pwm
    import ffbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic enable,
    input wire logic [6:0] duty_pct,
    input wire logic [PWM_W-1:0] period_cycles,
    output logic pwm_n
);
    logic [PWM_W-1:0] cnt, next_cnt;
    logic [PWM_W-1:0] low_cyc, next_low_cyc;
    logic next_pwm_n;

    always_comb begin
        next_cnt = cnt + 1'b1;
        next_low_cyc = low_cyc;
        // Duty latched once per period so a change never makes a runt pulse
        if (cnt + 1'b1 >= period_cycles) begin
            next_cnt = '0;
            next_low_cyc = PWM_W'((48'(period_cycles) * 48'(duty_pct)) / 48'(PCT_FULL));
        end
        // Low output energises the solenoid; low time equals duty share
        next_pwm_n = !(enable && (next_cnt < next_low_cyc));
        if (!enable || period_cycles == '0) begin
            next_cnt = '0;
            next_pwm_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
            low_cyc <= '0;
            pwm_n <= 1'b1;
        end else if (ce) begin
            cnt <= next_cnt;
            low_cyc <= next_low_cyc;
            pwm_n <= next_pwm_n;
        end
    end
endmodule : ffbp_pwm

// ==== ffbp_top.sv ====
// Flex fuel sensor decode, lambda blend, crank adder and boost solenoid drive
// How it works
// - Frequency 50..150 Hz maps to 0..100 percent.
// - Near 170 Hz flags contamination fail-safe.
// - Width 1..5 ms maps to -40..125 C.
// - Blend 0 uses base, 1 uses ethanol.
// - Between, weight ethanol by factor, base rest.
// - Add ethanol crank pulse on normal crank fuel.
// - Output low energises solenoid, high releases.
// - Duty equals low fraction of period.
// - PWM period is configurable, e.g. 30 Hz.
// - Output enable gates all solenoid drive.
// - Feedback enable adds closed-loop trim, else open.
// - Solenoid switched low side, other end supply.
// - Duty clamped to configurable maximum.
`timescale 1ns/1ps
module ffbp_top
    import ffbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic composition_sensor,
    input wire logic [FRAC_W-1:0] lambda_blend_factor_table,
    input wire logic [LAMBDA_W-1:0] base_lambda_target,
    input wire logic [LAMBDA_W-1:0] ethanol_lambda_target,
    input wire logic [FUEL_W-1:0] crank_fuel_base,
    input wire logic [FUEL_W-1:0] ethanol_crank_fuel_extra,
    input wire ffbp_boost_cfg_t boost_cfg,
    output ffbp_sensor_t sensor,
    output logic [LAMBDA_W-1:0] lambda_target,
    output logic [FUEL_W-1:0] crank_fuel_total,
    output logic [6:0] boost_duty_applied,
    output logic boost_lowside_driver
);
    ////////////////////////////////////////////////////////////////////////////
    // Sensor edge capture
    logic in_q, next_in_q;
    logic [CNT_W-1:0] per_cnt, next_per_cnt;
    logic [CNT_W-1:0] hi_cnt, next_hi_cnt;
    logic [CNT_W-1:0] hi_meas, next_hi_meas;
    ffbp_sensor_t next_sensor;
    logic rise, fall;

    // Linear map of x in [lo,hi] to 0..span, saturated at both ends
    function automatic logic [7:0] lin_map(input logic [CNT_W-1:0] x,
                                           input logic [CNT_W-1:0] lo,
                                           input logic [CNT_W-1:0] hi,
                                           input logic [7:0] span);
        logic [31:0] num;
        num = 32'h0;
        if (x <= lo) begin
            lin_map = 8'h00;
        end else if (x >= hi) begin
            lin_map = span;
        end else begin
            num = 32'(x - lo) * 32'(span);
            lin_map = 8'(num / 32'(hi - lo));
        end
    endfunction : lin_map

    assign rise = composition_sensor && !in_q;
    assign fall = !composition_sensor && in_q;

    always_comb begin
        next_in_q = composition_sensor;
        next_per_cnt = per_cnt;
        next_hi_cnt = hi_cnt;
        next_hi_meas = hi_meas;
        next_sensor = sensor;
        if (per_cnt != CNT_W'(TIMEOUT_CYC)) begin
            next_per_cnt = per_cnt + 1'b1;
        end
        if (composition_sensor) begin
            next_hi_cnt = hi_cnt + 1'b1;
        end
        if (fall) begin
            next_hi_meas = hi_cnt;
        end
        if (rise) begin
            next_per_cnt = CNT_W'(1);
            next_hi_cnt = CNT_W'(1);
            // The very first rise only starts timing; period is bogus
            if (per_cnt != CNT_W'(TIMEOUT_CYC) && per_cnt != '0) begin
                next_sensor.reading_valid = 1'b1;
                // Shorter period means higher frequency; 170 Hz or above is fail-safe
                next_sensor.fail_safe = per_cnt <= CNT_W'(PER_FAIL_CYC);
                if (per_cnt > CNT_W'(PER_FAIL_CYC)) begin
                    // Content rises as period falls: map reversed period
                    next_sensor.ethanol_content = 7'(lin_map(
                        CNT_W'(PER_MAX_CYC) - (per_cnt > CNT_W'(PER_MAX_CYC) ?
                        CNT_W'(PER_MAX_CYC) : per_cnt), '0,
                        CNT_W'(PER_MAX_CYC - PER_MIN_CYC), {1'b0, PCT_FULL}));
                end
                next_sensor.fuel_temp_c = 8'(TEMP_MIN_C) + 8'(lin_map(hi_meas,
                    CNT_W'(PW_MIN_CYC), CNT_W'(PW_MAX_CYC),
                    8'(TEMP_MAX_C - TEMP_MIN_C)));
            end
        end else if (per_cnt == CNT_W'(TIMEOUT_CYC)) begin
            // Dead input: content is held, only validity drops
            next_sensor.reading_valid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_q <= 1'b0;
            // Start as timed out so the first rise after reset only starts timing
            per_cnt <= CNT_W'(TIMEOUT_CYC);
            hi_cnt <= '0;
            hi_meas <= '0;
            sensor <= '{ethanol_content: ETH_RESET[6:0], fuel_temp_c: 8'h00,
                        reading_valid: 1'b0, fail_safe: 1'b0};
        end else if (ce) begin
            in_q <= next_in_q;
            per_cnt <= next_per_cnt;
            hi_cnt <= next_hi_cnt;
            hi_meas <= next_hi_meas;
            sensor <= next_sensor;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lambda blend and crank fuel
    logic [LAMBDA_W-1:0] next_lambda_target;
    logic [FUEL_W-1:0] next_crank_fuel_total;
    logic [LAMBDA_W+FRAC_W:0] blend_sum;

    always_comb begin
        // Exact ends pass base or ethanol target straight through at factors 0 and 1.0
        // Widen each operand first so no product is formed at table width
        blend_sum = (LAMBDA_W+FRAC_W+1)'(ethanol_lambda_target)
            * (LAMBDA_W+FRAC_W+1)'(lambda_blend_factor_table)
            + (LAMBDA_W+FRAC_W+1)'(base_lambda_target)
            * (LAMBDA_W+FRAC_W+1)'(FRAC_ONE - lambda_blend_factor_table);
        next_lambda_target = LAMBDA_W'(blend_sum / (LAMBDA_W+FRAC_W+1)'(FRAC_ONE));
        if (lambda_blend_factor_table == '0) begin
            next_lambda_target = base_lambda_target;
        end else if (lambda_blend_factor_table == FRAC_ONE) begin
            next_lambda_target = ethanol_lambda_target;
        end
        // Saturate rather than wrap the injector pulse
        next_crank_fuel_total = crank_fuel_base + ethanol_crank_fuel_extra;
        if (next_crank_fuel_total < crank_fuel_base) begin
            next_crank_fuel_total = '1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lambda_target <= '0;
            crank_fuel_total <= '0;
        end else if (ce) begin
            lambda_target <= next_lambda_target;
            crank_fuel_total <= next_crank_fuel_total;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boost duty selection and clamp
    logic [6:0] next_duty;
    logic signed [9:0] duty_sum;
    logic [6:0] max_lim;

    always_comb begin
        max_lim = (boost_cfg.max_duty > PCT_FULL) ? PCT_FULL : boost_cfg.max_duty;
        duty_sum = $signed({3'b000, boost_cfg.open_loop_duty});
        if (boost_cfg.feedback_enable) begin
            duty_sum = duty_sum + 10'(boost_cfg.feedback_trim);
        end
        if (duty_sum < 0) begin
            next_duty = '0;
        end else if (duty_sum > $signed({3'b000, max_lim})) begin
            next_duty = max_lim;
        end else begin
            next_duty = duty_sum[6:0];
        end
        if (!boost_cfg.output_enable) begin
            next_duty = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boost_duty_applied <= '0;
        end else if (ce) begin
            boost_duty_applied <= next_duty;
        end
    end

    // Drives a low-side switch; the solenoid's far end sits on switched supply
    ffbp_pwm u_pwm (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .enable(boost_cfg.output_enable),
        .duty_pct(boost_duty_applied),
        .period_cycles(boost_cfg.period_cycles),
        .pwm_n(boost_lowside_driver)
    );
endmodule : ffbp_top

// ==== tb_top.sv ====
// Self-checking bench for the flex fuel and boost block
`timescale 1ns/1ps
module tb_top
    import ffbp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] fac = 8'h00;
    logic [15:0] lb = 16'h0, le = 16'h0, fb = 16'h0, fx = 16'h0, lam, crank;
    ffbp_boost_cfg_t cfg = '0;
    logic [21:0] per = 22'h0, wid = 22'h0;
    logic wave, drive_n, coil;
    ffbp_sensor_t sensor;
    logic [6:0] duty;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    logic [31:0] seed = 32'h25ae;
    always #12.5 clk = ~clk;
    ffbp_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .composition_sensor(wave),
        .lambda_blend_factor_table(fac), .base_lambda_target(lb), .ethanol_lambda_target(le),
        .crank_fuel_base(fb), .ethanol_crank_fuel_extra(fx), .boost_cfg(cfg), .sensor(sensor),
        .lambda_target(lam), .crank_fuel_total(crank), .boost_duty_applied(duty),
        .boost_lowside_driver(drive_n));
    ffbp_partner u_partner (.clk(clk), .period(per), .width(wid), .drive_n(drive_n),
        .wave(wave), .energised(coil));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_blend(input logic [7:0] f, input logic [15:0] b, e);
        if (f == 8'h00) return b;
        if (f == 8'hff) return e;
        return 16'((32'(e) * f + 32'(b) * (8'hff - f)) / 32'hff);
    endfunction : exp_blend
    function automatic logic [6:0] exp_duty(input ffbp_boost_cfg_t c);
        int s;
        int m;
        s = c.open_loop_duty + (c.feedback_enable ? int'(c.feedback_trim) : 0);
        m = c.max_duty > 7'h64 ? 100 : c.max_duty;
        s = s < 0 ? 0 : s > m ? m : s;
        return c.output_enable ? 7'(s) : 7'h00;
    endfunction : exp_duty
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // Whole run needs under 8000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ffbp_boost_cfg_t t;
        logic [31:0] lows;
        logic [15:0] hold;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        per <= 22'h7d0;
        wid <= 22'h3e8;
        @(posedge clk);
        #1;
        check(drive_n, 1'b1);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            fac <= i == 0 ? 8'h00 : i == 1 ? 8'hff : i == 2 ? 8'h4d : 8'(rnd());
            lb <= 16'(rnd());
            le <= 16'(rnd());
            fb <= 16'(rnd());
            fx <= i == 3 ? 16'hffff : 16'(rnd());
            @(posedge clk);
            #1;
            check(lam, exp_blend(fac, lb, le));
            check(crank, {1'b0, fb} + fx > 17'hffff ? 16'hffff : fb + fx);
        end
        // Clock enable low must freeze the blend result although inputs move
        @(posedge clk);
        hold = exp_blend(fac, lb, le);
        ce <= 1'b0;
        fac <= 8'h00;
        lb <= ~lb;
        repeat (3) @(posedge clk);
        #1;
        check(lam, hold);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        #1;
        check(lam, lb);
        for (int i = 0; i < 40; i++) begin
            t = 48'({rnd(), rnd()});
            t.open_loop_duty = 7'(rnd() % 101);
            t.period_cycles = 24'h4;
            if (i == 0) t = '{1'b1, 1'b1, 7'h05, 8'h80, 7'h32, 24'h4};
            if (i == 1) t = '{1'b1, 1'b1, 7'h64, 8'h7f, 7'h7f, 24'h4};
            @(posedge clk);
            cfg <= t;
            @(posedge clk);
            #1;
            check(duty, exp_duty(cfg));
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            cfg <= '{k < 2, 1'b0, k ? 7'h14 : 7'h32, 8'h00, 7'h64, k ? 24'ha : 24'h4};
            repeat (40) @(posedge clk);
            #1;
            lows = 0;
            repeat (100) begin
                @(posedge clk);
                #1;
                lows += coil;
            end
            check(lows, k == 2 ? 0 : k ? 20 : 50);
        end
        repeat (6000) @(posedge clk);
        #1;
        check(sensor.fail_safe, 1'b1);
        check(sensor.ethanol_content, 7'h00);
        check(sensor.reading_valid, 1'b1);
        check(sensor.fuel_temp_c, 8'(TEMP_MIN_C));
        results();
    end
endmodule : tb_top
bind ffbp_top ffbp_assertions u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
    .composition_sensor(composition_sensor), .lambda_blend_factor_table(lambda_blend_factor_table),
    .base_lambda_target(base_lambda_target), .ethanol_lambda_target(ethanol_lambda_target),
    .crank_fuel_base(crank_fuel_base), .ethanol_crank_fuel_extra(ethanol_crank_fuel_extra),
    .boost_cfg(boost_cfg), .sensor(sensor), .lambda_target(lambda_target),
    .crank_fuel_total(crank_fuel_total), .boost_duty_applied(boost_duty_applied),
    .boost_lowside_driver(boost_lowside_driver));
